// [src/clock_monitor_map.vh]
// Register offsets, field positions, reset values, codes and timing counts
// of the serial audio port clock monitor.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CLOCK_MONITOR_MAP_VH
`define CLOCK_MONITOR_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_RATE_RATIO   8'h28
`define OFS_CHECK_MASK   8'h29
`define OFS_OUT_SOURCE   8'h30
`define OFS_POLARITY     8'h31
`define OFS_FRAME_FMT    8'h33
`define OFS_DATA_OFFSET  8'h34
`define OFS_DETECT_STAT  8'h39

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define RST_ZERO         8'h00
`define RST_FRAME_FMT    8'h02
`define POL_RW_MASK      8'hF1
`define BIT_IGN_PLL      6
`define BIT_IGN_RANGE    5
`define BIT_IGN_RATE     4
`define BIT_IGN_RATIO    3
`define BIT_IGN_LOSS     2
`define BIT_OUT_SRC      0
`define BIT_BCLK_INV     5
`define BIT_OFS_MSB      7
`define ST_LOSS          0
`define ST_RATIO         1
`define ST_RANGE         2
`define ST_PLL           3
`define ST_RATE          4
`define ST_ERROR         5

// ****************************************************************
// Codes
// ****************************************************************
`define RATIO_32         4'h3
`define RATIO_64         4'h5
`define RATIO_128        4'h7
`define RATIO_256        4'h9
`define RATIO_512        4'hB
`define MODE_AUTO        4'h0
`define MODE_32K         4'h6
`define MODE_48K         4'h9
`define MODE_96K         4'hB
`define MODE_192K        4'hD
`define FMT_I2S          2'h0
`define FMT_TDM          2'h1
`define FMT_RTJ          2'h2
`define FMT_LTJ          2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CORE_CLK_KHZ     100000
`define BCLK_MIN_KHZ     256
`define BCLK_MAX_KHZ     50000
`define PLL_MAX_MHZ      150
`define BCLK_MAX_PER     (`CORE_CLK_KHZ / `BCLK_MIN_KHZ)
`define BCLK_MIN_PER     ((`CORE_CLK_KHZ + `BCLK_MAX_KHZ - 1) / `BCLK_MAX_KHZ)
`define LOSS_CYCLES      (4 * `BCLK_MAX_PER)
`define FRAME_LIMIT      8191
`define RATIO_MIN        32
`define RATIO_MAX        512

`endif

// [src/sync2.v]
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is a level that is independent of the others.
module sync2 #(
    parameter W = 3
) (
    // Clocking
    input  wire         core_clk,
    input  wire         nrst,
    input  wire         ce,
    // Levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end else if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // sync2

// [src/period_meter.v]
// Edge finder and period counter for one synchronised level.
// Assumes the input already passed a synchroniser on core_clk.
module period_meter #(
    parameter W     = 12,
    parameter LIMIT = 1560
) (
    // Clocking
    input  wire         core_clk,
    input  wire         nrst,
    input  wire         ce,
    // Measured level
    input  wire         sig,
    // Results
    output wire         rise,
    output wire         fall,
    output reg  [W-1:0] period,
    output reg          lost
);

    reg         prev_reg;
    reg [W-1:0] cnt_reg;

    assign rise = sig & ~prev_reg;
    assign fall = ~sig & prev_reg;

    // Count cycles between rising edges; saturate so a dead clock reads as lost
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            cnt_reg  <= {W{1'b0}};
            period   <= {W{1'b0}};
            lost     <= 1'b1;
        end else if (ce) begin
            prev_reg <= sig;
            if (rise) begin
                period  <= cnt_reg + 1'b1;
                cnt_reg <= {W{1'b0}};
                lost    <= 1'b0;
            end else if (cnt_reg >= LIMIT[W-1:0]) begin
                lost    <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

endmodule // period_meter

// [src/audio_port_clock_monitor.v]
// Clock checking, rate and ratio detection, and format control of a serial
// audio input port, with its control registers.
// Assumes an external source drives bit, frame and data pins asynchronously,
// and that the PLL rate and processed data come from core_clk logic.
`include "clock_monitor_map.vh"

module audio_port_clock_monitor (
    // Clock, reset and enable
    input  wire        core_clk,
    input  wire        nrst,
    input  wire        ce,
    // Audio pins from the source
    input  wire        bit_clk,
    input  wire        frame_clk,
    input  wire        serial_in,
    // Core-side inputs
    input  wire [7:0]  pll_freq_mhz,
    input  wire        processed_data,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_we,
    input  wire        reg_re,
    output reg  [7:0]  reg_rdata,
    // Results
    output reg         clock_error,
    output reg  [3:0]  active_rate_mode,
    output reg  [31:0] rx_sample,
    output reg         rx_valid,
    output reg         serial_data_output
);

    // ****************************************************************
    // Nominal frame periods in core cycles
    // ****************************************************************
    localparam integer PER_32K  = `CORE_CLK_KHZ / 32;
    localparam integer PER_48K  = `CORE_CLK_KHZ / 48;
    localparam integer PER_96K  = `CORE_CLK_KHZ / 96;
    localparam integer PER_192K = `CORE_CLK_KHZ / 192;

    // ****************************************************************
    // Pin synchronisation and edge measurement
    // ****************************************************************
    wire [2:0]  pins_s;
    wire        bclk_s = pins_s[0];
    wire        fclk_s = pins_s[1];
    wire        din_s  = pins_s[2];
    wire        b_rise;
    wire        b_fall;
    wire [11:0] b_per;
    wire        b_lost;
    wire        f_rise;
    wire [12:0] f_per;
    wire        f_lost;

    sync2 #(
        .W (3)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .d        ({serial_in, frame_clk, bit_clk}),
        .q        (pins_s)
    );

    period_meter #(
        .W     (12),
        .LIMIT (`LOSS_CYCLES)
    ) u_bclk_meter (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .sig      (bclk_s),
        .rise     (b_rise),
        .fall     (b_fall),
        .period   (b_per),
        .lost     (b_lost)
    );

    period_meter #(
        .W     (13),
        .LIMIT (`FRAME_LIMIT)
    ) u_fclk_meter (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .sig      (fclk_s),
        .rise     (f_rise),
        .fall     (),
        .period   (f_per),
        .lost     (f_lost)
    );

    // ****************************************************************
    // Control registers
    // ****************************************************************
    reg [3:0] mode_reg;
    reg [3:0] ratio_field_reg;
    reg [7:0] mask_reg;
    reg [7:0] src_reg;
    reg [7:0] pol_reg;
    reg [7:0] fmt_reg;
    reg [7:0] ofs_reg;
    reg [5:0] status_reg;

    // Software writes; the ratio nibble belongs to hardware alone
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= `MODE_AUTO;
            mask_reg <= `RST_ZERO;
            src_reg  <= `RST_ZERO;
            pol_reg  <= `RST_ZERO;
            fmt_reg  <= `RST_FRAME_FMT;
            ofs_reg  <= `RST_ZERO;
        end else if (ce && reg_we) begin
            case (reg_addr)
                `OFS_RATE_RATIO:  mode_reg <= reg_wdata[3:0];
                `OFS_CHECK_MASK:  mask_reg <= reg_wdata;
                `OFS_OUT_SOURCE:  src_reg  <= reg_wdata;
                `OFS_POLARITY:    pol_reg  <= reg_wdata & `POL_RW_MASK;
                `OFS_FRAME_FMT:   fmt_reg  <= reg_wdata;
                `OFS_DATA_OFFSET: ofs_reg  <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read data is registered; unmapped offsets read zero
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `RST_ZERO;
        end else if (ce && reg_re) begin
            case (reg_addr)
                `OFS_RATE_RATIO:  reg_rdata <= {ratio_field_reg, mode_reg};
                `OFS_CHECK_MASK:  reg_rdata <= mask_reg;
                `OFS_OUT_SOURCE:  reg_rdata <= src_reg;
                `OFS_POLARITY:    reg_rdata <= pol_reg;
                `OFS_FRAME_FMT:   reg_rdata <= fmt_reg;
                `OFS_DATA_OFFSET: reg_rdata <= ofs_reg;
                `OFS_DETECT_STAT: reg_rdata <= {2'b00, status_reg};
                default:          reg_rdata <= `RST_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // Bit clocks per frame
    // ****************************************************************
    reg [9:0] ratio_cnt_reg;
    reg [9:0] ratio_meas_reg;
    reg [9:0] ratio_prev_reg;
    reg [1:0] frames_seen_reg;
    reg       meas_new_reg;
    reg [3:0] ratio_code;

    // Saturating count, so an absurd ratio still reads as out of range
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ratio_cnt_reg   <= 10'h000;
            ratio_meas_reg  <= 10'h000;
            ratio_prev_reg  <= 10'h000;
            frames_seen_reg <= 2'h0;
            meas_new_reg    <= 1'b0;
        end else if (ce) begin
            meas_new_reg <= f_rise;
            if (f_rise) begin
                ratio_cnt_reg  <= {9'h000, b_rise};
                ratio_meas_reg <= ratio_cnt_reg;
                ratio_prev_reg <= ratio_meas_reg;
                if (frames_seen_reg != 2'h3) begin
                    frames_seen_reg <= frames_seen_reg + 2'h1;
                end
            end else if (b_rise && ratio_cnt_reg != 10'h3FF) begin
                ratio_cnt_reg <= ratio_cnt_reg + 10'h001;
            end
        end
    end

    // Code for the measured ratio; zero when it is not a listed ratio
    always @* begin
        case (ratio_meas_reg)
            10'h020: ratio_code = `RATIO_32;
            10'h040: ratio_code = `RATIO_64;
            10'h080: ratio_code = `RATIO_128;
            10'h100: ratio_code = `RATIO_256;
            10'h200: ratio_code = `RATIO_512;
            default: ratio_code = 4'h0;
        endcase
    end

    // Keep the last valid code while the ratio is odd
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ratio_field_reg <= 4'h0;
        end else if (ce && meas_new_reg && ratio_code != 4'h0) begin
            ratio_field_reg <= ratio_code;
        end
    end

    // ****************************************************************
    // Frame rate detection
    // ****************************************************************
    function near;
        input [12:0]  p;
        input integer nom;
        begin
            near = (p >= nom - nom / 32) && (p <= nom + nom / 32);
        end
    endfunction

    reg [3:0] det_code;
    wire      mode_auto = (mode_reg == `MODE_AUTO);
    wire      mode_legal = (mode_reg == `MODE_32K) || (mode_reg == `MODE_48K) ||
                           (mode_reg == `MODE_96K) || (mode_reg == `MODE_192K);

    // Only the 48 kHz and 32 kHz families are recognised automatically
    always @* begin
        if (f_lost) begin
            det_code = 4'h0;
        end else if (near(f_per, PER_32K)) begin
            det_code = `MODE_32K;
        end else if (near(f_per, PER_48K)) begin
            det_code = `MODE_48K;
        end else if (near(f_per, PER_96K)) begin
            det_code = `MODE_96K;
        end else if (near(f_per, PER_192K)) begin
            det_code = `MODE_192K;
        end else begin
            det_code = 4'h0;
        end
    end

    // ****************************************************************
    // Fault checks and combined error
    // ****************************************************************
    wire fault_loss  = b_lost;
    wire fault_range = b_lost ||
                       (b_per > `BCLK_MAX_PER) ||
                       (b_per < `BCLK_MIN_PER);
    wire fault_ratio = (frames_seen_reg < 2'h2) ||
                       (ratio_meas_reg < `RATIO_MIN) ||
                       (ratio_meas_reg > `RATIO_MAX) ||
                       (ratio_meas_reg != ratio_prev_reg);
    wire fault_pll   = (pll_freq_mhz >= `PLL_MAX_MHZ);
    wire fault_rate  = mode_auto ? (det_code == 4'h0)
                                 : ~mode_legal;

    wire [5:0] status_next = {1'b0, fault_rate, fault_pll,
                              fault_range, fault_ratio, fault_loss};

    wire err_next =
        (fault_pll   & ~mask_reg[`BIT_IGN_PLL])   |
        (fault_range & ~mask_reg[`BIT_IGN_RANGE]) |
        (fault_rate  & ~mask_reg[`BIT_IGN_RATE])  |
        (fault_ratio & ~mask_reg[`BIT_IGN_RATIO]) |
        (fault_loss  & ~mask_reg[`BIT_IGN_LOSS]);

    // Re-evaluated every enabled cycle; status shows raw faults
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg       <= 6'h00;
            clock_error      <= 1'b0;
            active_rate_mode <= `MODE_AUTO;
        end else if (ce) begin
            status_reg       <= status_next | {err_next, 5'h00};
            clock_error      <= err_next;
            active_rate_mode <= mode_auto ? det_code : mode_reg;
        end
    end

    // ****************************************************************
    // Frame decoding and sample capture
    // ****************************************************************
    wire       inv      = pol_reg[`BIT_BCLK_INV];
    wire       s_edge   = inv ? b_fall : b_rise;
    wire       c_edge   = inv ? b_rise : b_fall;
    wire [1:0] fmt      = fmt_reg[5:4];
    wire [8:0] offset   = {fmt_reg[`BIT_OFS_MSB], ofs_reg};
    wire [9:0] half     = {1'b0, ratio_meas_reg[9:1]};
    reg  [5:0] wl;
    reg  [10:0] start_pos;

    // Sample width from the word length field
    always @* begin
        case (fmt_reg[1:0])
            2'h0:    wl = 6'd16;
            2'h1:    wl = 6'd20;
            2'h2:    wl = 6'd24;
            default: wl = 6'd32;
        endcase
    end

    // First captured bit position inside the frame
    always @* begin
        case (fmt)
            `FMT_I2S: start_pos = {2'b00, offset} + 11'd1;
            `FMT_RTJ: start_pos = {1'b0, half} - {5'h00, wl} +
                                  {2'b00, offset};
            default:  start_pos = {2'b00, offset};
        endcase
    end

    reg         fr_prev_reg;
    reg  [9:0]  bit_idx_reg;
    reg  [5:0]  got_reg;
    reg  [31:0] shift_reg;

    // I2S starts on the frame's fall, the others on its rise
    wire        is_start = (fmt == `FMT_I2S) ? (fr_prev_reg & ~fclk_s)
                                             : (~fr_prev_reg & fclk_s);
    wire [9:0]  cur_idx  = is_start ? 10'h000 : bit_idx_reg;
    wire [5:0]  cur_got  = is_start ? 6'h00 : got_reg;
    wire [31:0] cur_sh   = is_start ? 32'h0000_0000 : shift_reg;
    wire        capture  = ({1'b0, cur_idx} >= start_pos) && (cur_got < wl);
    wire [31:0] sh_next  = {cur_sh[30:0], din_s};
    wire [5:0]  got_next = cur_got + 6'h01;

    // Shift in one bit per sampling edge of the bit clock
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fr_prev_reg <= 1'b0;
            bit_idx_reg <= 10'h3FF;
            got_reg     <= 6'h00;
            shift_reg   <= 32'h0000_0000;
            rx_sample   <= 32'h0000_0000;
            rx_valid    <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            if (s_edge) begin
                fr_prev_reg <= fclk_s;
                if (cur_idx != 10'h3FF) begin
                    bit_idx_reg <= cur_idx + 10'h001;
                end else begin
                    bit_idx_reg <= cur_idx;
                end
                shift_reg <= cur_sh;
                got_reg   <= cur_got;
                if (capture) begin
                    shift_reg <= sh_next;
                    got_reg   <= got_next;
                    if (got_next == wl) begin
                        rx_sample <= sh_next;
                        rx_valid  <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Serial data output
    // ****************************************************************
    // Updated on the change edge so the far end samples a settled level
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_data_output <= 1'b0;
        end else if (ce && c_edge) begin
            serial_data_output <= src_reg[`BIT_OUT_SRC] ? din_s
                                                        : processed_data;
        end
    end

endmodule // audio_port_clock_monitor

// [dv/audio_port_clock_monitor_properties.sv]
// Concurrent checks on the ports of the serial audio port clock monitor.
// Assumes the bench keeps ce high apart from short pauses.
// ****************************************************************
// Checker
// ****************************************************************
module audio_port_clock_monitor_properties (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       ce,
    // Watched inputs
    input wire logic       bit_clk,
    input wire logic [7:0] pll_freq_mhz,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    input wire logic       reg_re,
    // Watched outputs
    input wire logic [7:0] reg_rdata,
    input wire logic       clock_error,
    input wire logic [3:0] active_rate_mode,
    input wire logic       rx_valid
);
    localparam int LOSS_WAIT = 1600;
    logic [7:0]  mask_reg, src_reg, pol_reg, fmt_reg;
    logic [3:0]  mode_reg;
    logic [11:0] idle_reg;
    logic        bclk_reg;
    wire         wr_ok = ce && reg_we;
    // Shadows of the writable fields except the data offset; idle count saturates to avoid wrap
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= 8'h00;
            src_reg  <= 8'h00;
            pol_reg  <= 8'h00;
            fmt_reg  <= 8'h02;
            mode_reg <= 4'h0;
            idle_reg <= 12'h000;
            bclk_reg <= 1'b0;
        end else begin
            if (wr_ok && reg_addr == 8'h29) mask_reg <= reg_wdata;
            if (wr_ok && reg_addr == 8'h30) src_reg <= reg_wdata;
            if (wr_ok && reg_addr == 8'h31) pol_reg <= reg_wdata;
            if (wr_ok && reg_addr == 8'h33) fmt_reg <= reg_wdata;
            if (wr_ok && reg_addr == 8'h28) mode_reg <= reg_wdata[3:0];
            bclk_reg <= bit_clk;
            idle_reg <= (bit_clk != bclk_reg) ? 12'h000 :
                        (idle_reg == 12'hFFF) ? idle_reg : idle_reg + 12'h001;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence rd_at(logic [7:0] a);
        ce && reg_re && !reg_we && reg_addr == a;
    endsequence
    sequence forced_held;
        (ce && mode_reg inside {4'h6, 4'h9, 4'hB, 4'hD} && $stable(mode_reg)) [*3];
    endsequence
    chk_mask_read: assert property (rd_at(8'h29) |=> reg_rdata == mask_reg)
        else $error("mask read mismatch");
    chk_src_read: assert property (rd_at(8'h30) |=> reg_rdata == src_reg)
        else $error("source read mismatch");
    chk_pol_read: assert property (rd_at(8'h31) |=> reg_rdata == (pol_reg & 8'hF1))
        else $error("polarity read mismatch");
    chk_fmt_read: assert property (rd_at(8'h33) |=> reg_rdata == fmt_reg)
        else $error("format read mismatch");
    chk_ratio_code: assert property (rd_at(8'h28) |=>
        reg_rdata[7:4] inside {4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB} && reg_rdata[3:0] == mode_reg)
        else $error("ratio field mismatch");
    chk_pll_flag: assert property (ce && pll_freq_mhz >= 8'h96 && !mask_reg[6] |=> clock_error)
        else $error("pll fault not flagged");
    chk_loss_flag: assert property (ce && idle_reg >= LOSS_WAIT && !mask_reg[2] |=> clock_error)
        else $error("bit clock loss not flagged");
    chk_all_masked: assert property (ce && $past(ce) && mask_reg[6:2] == 5'h1F &&
        $past(mask_reg[6:2]) == 5'h1F |-> !clock_error)
        else $error("error raised with all checks ignored");
    chk_forced_mode: assert property (forced_held |-> active_rate_mode == mode_reg)
        else $error("forced rate mode not applied");
    chk_valid_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("sample strobe longer than one cycle");
endmodule // audio_port_clock_monitor_properties

bind audio_port_clock_monitor audio_port_clock_monitor_properties i_props (.core_clk, .nrst,
    .ce, .bit_clk, .pll_freq_mhz, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .clock_error, .active_rate_mode, .rx_valid);

// [dv/audio_source_model.sv]
// Behavioural audio source: left-justified frames of 256 bit clocks.
// Assumes a 125 ns bit clock; the clock stops at the next frame boundary while run is low.
module audio_source_model (
    // Control from the bench
    input  wire logic        run,
    input  wire logic        inv,
    input  wire logic [31:0] word,
    // Pins towards the port
    output logic             bit_clk,
    output logic             frame_clk,
    output logic             serial_in
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BITS = 256;
    logic pol;
    // Polarity is latched per frame so a change never splits a frame
    initial begin
        bit_clk = 1'b0;
        frame_clk = 1'b0;
        serial_in = 1'b0;
        forever begin
            wait (run);
            pol = inv;
            for (int i = 0; i < BITS; i++) begin
                bit_clk = pol;
                frame_clk = (i < BITS / 2);
                serial_in = (i < 32) ? word[31 - i] : ~serial_in;
                #62.5 bit_clk = ~pol;
                #62.5;
            end
        end
    end
endmodule // audio_source_model

// [dv/tb_audio_port_clock_monitor.sv]
// Self-checking bench for the serial audio port clock monitor.
// Assumes the source model drives the pins and the checker is bound in.
// ****************************************************************
// Bench
// ****************************************************************
module tb_audio_port_clock_monitor;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0, nrst = 1'b0, ce = 1'b1, processed_data = 1'b0;
    logic        reg_we = 1'b0, reg_re = 1'b0, run = 1'b0, inv = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, pll_freq_mhz = 8'h00, rd_v, f;
    logic [31:0] word = 32'h0, seed = 32'h20, v;
    logic [3:0]  modes [4] = '{4'h6, 4'h9, 4'hB, 4'hD};
    wire         bit_clk, frame_clk, serial_in, clock_error, rx_valid, serial_data_output;
    wire  [7:0]  reg_rdata;
    wire  [3:0]  active_rate_mode;
    wire  [31:0] rx_sample;
    int          err_total = 0, compares = 0, cycles = 0;
    audio_port_clock_monitor i_audio_port_clock_monitor (.core_clk, .nrst, .ce, .bit_clk,
        .frame_clk, .serial_in, .pll_freq_mhz, .processed_data, .reg_addr, .reg_wdata,
        .reg_we, .reg_re, .reg_rdata, .clock_error, .active_rate_mode, .rx_sample,
        .rx_valid, .serial_data_output);
    audio_source_model i_audio_source_model (.run, .inv, .word, .bit_clk, .frame_clk,
        .serial_in);
    // Clock and hang guard (run needs about 25000 cycles)
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Captured sample is right aligned, so the word loses its low bits
    function automatic logic [31:0] exp_rx(input logic [31:0] w, input logic [1:0] wl);
        return (wl == 2'h3) ? w : w >> (16 - 4 * wl);
    endfunction
    task automatic compare_val(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d, err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge core_clk);
        reg_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_re = 1'b1;
        @(negedge core_clk);
        reg_re = 1'b0;
        rd_v = reg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        compare_val($sformatf("reg %0h", a), {24'h0, e}, {24'h0, rd_v});
    endtask
    task automatic err_after(input logic e);
        repeat (4) @(negedge core_clk);
        compare_val("clock_error", {31'h0, e}, {31'h0, clock_error});
    endtask
    task automatic wait_rx();
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 4000);
        compare_val("rx_valid", 32'h1, {31'h0, rx_valid});
    endtask
    // Main sequence: reset values, access, faults, stream, manual modes
    initial begin
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        rchk(8'h29, 8'h00);
        rchk(8'h30, 8'h00);
        rchk(8'h31, 8'h00);
        rchk(8'h33, 8'h02);
        rchk(8'h34, 8'h00);
        rchk(8'h40, 8'h00);
        ce = 1'b0;
        wr(8'h30, 8'h01);
        ce = 1'b1;
        rchk(8'h30, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            wr(8'h30, v[7:0]);
            rchk(8'h30, v[7:0]);
            wr(8'h31, v[15:8]);
            rchk(8'h31, v[15:8] & 8'hF1);
            wr(8'h33, v[23:16]);
            rchk(8'h33, v[23:16]);
            wr(8'h34, v[31:24]);
            rchk(8'h34, v[31:24]);
        end
        wr(8'h34, 8'h00);
        // Bit clock still stopped: loss alone must raise the error
        repeat (1700) @(negedge core_clk);
        err_after(1'b1);
        wr(8'h29, 8'h7C);
        err_after(1'b0);
        wr(8'h29, 8'h78);
        err_after(1'b1);
        wr(8'h29, 8'h00);
        for (int p = 0; p < 2; p++) begin
            v = xs();
            word = v;
            inv = p[0];
            processed_data = v[2];
            f = {2'b00, ~p[0], 1'b1, 2'b00, v[1:0]};
            wr(8'h30, {7'h00, ~p[0]});
            wr(8'h31, p[0] ? 8'h20 : 8'h00);
            wr(8'h33, f);
            run = 1'b1;
            repeat (4) wait_rx();
            compare_val("rx_sample", exp_rx(v, f[1:0]), rx_sample);
            v = p[0] ? {31'h0, v[2]} : exp_rx(v, f[1:0]) & 32'h1;
            compare_val("serial out", v, {31'h0, serial_data_output});
        end
        rd(8'h28);
        compare_val("ratio", 32'h9, {28'h0, rd_v[7:4]});
        compare_val("rate", 32'h6, {28'h0, active_rate_mode});
        err_after(1'b0);
        pll_freq_mhz = 8'h96;
        err_after(1'b1);
        pll_freq_mhz = 8'h95;
        err_after(1'b0);
        wr(8'h29, 8'h40);
        pll_freq_mhz = 8'hC8;
        err_after(1'b0);
        pll_freq_mhz = 8'h00;
        wr(8'h29, 8'h00);
        foreach (modes[i]) begin
            wr(8'h28, {4'h0, modes[i]});
            err_after(1'b0);
            compare_val("mode", {28'h0, modes[i]}, {28'h0, active_rate_mode});
        end
        wr(8'h28, 8'h04);
        err_after(1'b1);
        wr(8'h29, 8'h10);
        err_after(1'b0);
        rd(8'h39);
        compare_val("rate status", 32'h1, {31'h0, rd_v[4]});
        tally_and_finish();
    end
endmodule // tb_audio_port_clock_monitor
